//--- aoc_pkg.sv
// Package of constants shared by the converter output and configuration port.
// Assumes one 100 MHz clock; every pin input is resampled inside the block.
package aoc_pkg;

  // ----------------------------------------------------------------
  // Widths and pin sampler layout
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int LANE_W = 8;
  localparam int SYNC_W = 6;
  localparam int ENC_IDX = 0;
  localparam int SCK_IDX = 1;
  localparam int CSN_IDX = 2;
  localparam int SDI_IDX = 3;
  localparam int SDOI_IDX = 4;
  localparam int PSS_IDX = 5;
  // Chip select idles high, so its filtered level starts high.
  localparam logic [5:0] SYNC_INIT = 6'h04;

  // ----------------------------------------------------------------
  // Serial frame: read flag, seven address bits, eight data bits
  // ----------------------------------------------------------------
  localparam int CNT_W = 4;
  localparam int ADDR_W = 7;
  localparam int REG_W = 8;
  localparam logic [3:0] ADDR_LAST_CNT = 4'h7;
  localparam logic [3:0] DATA_LAST_CNT = 4'hF;
  localparam logic [6:0] ADDR_FORMAT = 7'h01;
  localparam logic [6:0] ADDR_STAB = 7'h02;
  localparam logic [6:0] ADDR_FORM = 7'h03;
  localparam logic [7:0] FORMAT_RST = 8'h00;
  localparam logic [7:0] STAB_RST = 8'h00;
  localparam logic [7:0] FORM_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FMT_TWOS_BIT = 0;
  localparam int FMT_PWR_LSB = 1;
  localparam int STAB_EN_BIT = 0;
  localparam int STAB_PH_LSB = 1;
  localparam int FORM_LSB = 0;
  localparam int FORM_CUR_LSB = 2;
  localparam int FORM_TERM_BIT = 5;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FORM_FULL = 2'h0;
  localparam logic [1:0] FORM_DDR_CMOS = 2'h1;
  localparam logic [1:0] FORM_DDR_LVDS = 2'h2;
  localparam logic [1:0] PWR_AWAKE = 2'h0;
  localparam logic [2:0] CUR_DEFAULT = 3'h0;
  localparam logic [1:0] PHASE_NONE = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NAP_TIME_NS = 2000;
  localparam logic [7:0] NAP_COUNT = 8'(NAP_TIME_NS / CLK_PERIOD_NS);

endpackage : aoc_pkg

//--- aoc_pin_sync.sv
// Three-stage pin sampler with agreement filter and edge pulses.
// Assumes inputs are asynchronous to clk.
module aoc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------
  // Resampling chain
  // ----------------------------------------------------------------
  // Only the second stage reads the first, to keep metastability contained.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once the second and third stage agree.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= INIT;
      rise <= '0;
      fall <= '0;
    end else begin
      level <= (s2 & s3) | (level & (s2 | s3));
      rise <= ~level & s2 & s3;
      fall <= level & ~s2 & ~s3;
    end
  end

endmodule // aoc_pin_sync

//--- aoc_pair_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk.
module aoc_pair_buffer #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // Storage is not reset; only the pointers qualify it.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= 1'h0;
      rd_ptr <= 1'h0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'h0, push} - {1'h0, pop};
    end
  end

endmodule // aoc_pair_buffer

//--- aoc_adc_port.sv
// Digital output stream and configuration port of a 16-bit sampling converter.
// Assumes the conversion core answers conv_start with conv_valid on clk.
//
// Functional notes
// - Select pin low: serial port; high: straps.
// - Conversion starts on encode positive rising edge.
// - Shift only while chip select is low.
// - Sample serial data on serial clock rise.
// - Read-back bit valid for falling-edge capture.
// - Data out drives low only, open drain.
// - Parallel: chip select sets duty stabilizer.
// - Parallel: serial clock level sets output form.
// - Parallel: data pins select power-down state.
// - Full rate: sixteen parallel bits, top MSB.
// - Full rate: data changes on clock fall.
// - Double rate: data changes on both edges.
// - Lanes: even bit clock low, odd high.
// - Negative output clock inverts positive one.
// - Output clock phase delay is programmable.
// - Range flag high for out-of-range samples.
// - LVDS drive current and termination programmable.
// - Two's complement output format supported.
// - Parallel mode offers no double-rate CMOS.
// - Slow or stopped encode enters nap.
// - Serial: stabilizer register enables stabilizer.
// - Serial: output form register sets form.
module aoc_adc_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic encode_pos,
  input wire logic encode_neg,
  input wire logic program_style_select,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_in,
  output logic sdo_out,
  output logic sdo_oe,
  output logic conv_start,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire logic [15:0] conv_code,
  input wire logic conv_over,
  output logic [15:0] sample_bits,
  output logic [7:0] paired_bit_lanes,
  output logic range_exceeded_flag,
  output logic output_clock_pos,
  output logic output_clock_neg,
  output logic lvds_select,
  output logic [2:0] lvds_drive_current,
  output logic lvds_termination,
  output logic stabilizer_enable,
  output logic [1:0] power_state,
  output logic nap_state
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Picks the even or the odd bit of each pair onto the lanes.
  function automatic logic [7:0] lane_bits(input logic [15:0] word, input logic odd);
    logic [7:0] lanes;
    lanes = 8'h00;
    for (int i = 0; i < aoc_pkg::LANE_W; i++) begin
      lanes[i] = word[2 * i + int'(odd)];
    end
    return lanes;
  endfunction

  // Returns the content of an addressed mode register, zero if unmapped.
  function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] fmt,
                                          input logic [7:0] stab, input logic [7:0] form);
    logic [7:0] data;
    data = 8'h00;
    case (addr)
      aoc_pkg::ADDR_FORMAT: data = fmt;
      aoc_pkg::ADDR_STAB: data = stab;
      aoc_pkg::ADDR_FORM: data = form;
      default: data = 8'h00;
    endcase
    return data;
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_lvl;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic enc_rise;
  logic enc_fall;
  logic sck_rise;
  logic sck_fall;
  logic sck_lvl;
  logic csn_lvl;
  logic sdi_lvl;
  logic sdoin_lvl;
  logic serial_mode;

  // With the negative input grounded the positive input alone decides; driven
  // differentially the two agree, so one combined level serves both cases.
  assign pin_raw = {program_style_select, sdo_in, sdi, cs_n, sck,
                    encode_pos & ~encode_neg};

  aoc_pin_sync #(.W(aoc_pkg::SYNC_W), .INIT(aoc_pkg::SYNC_INIT)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pins(pin_raw),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign enc_rise = pin_rise[aoc_pkg::ENC_IDX];
  assign enc_fall = pin_fall[aoc_pkg::ENC_IDX];
  assign sck_rise = pin_rise[aoc_pkg::SCK_IDX];
  assign sck_fall = pin_fall[aoc_pkg::SCK_IDX];
  assign sck_lvl = pin_lvl[aoc_pkg::SCK_IDX];
  assign csn_lvl = pin_lvl[aoc_pkg::CSN_IDX];
  assign sdi_lvl = pin_lvl[aoc_pkg::SDI_IDX];
  assign sdoin_lvl = pin_lvl[aoc_pkg::SDOI_IDX];
  // The select pin is a strap; no glitch handling beyond sampling.
  assign serial_mode = ~pin_lvl[aoc_pkg::PSS_IDX];

  // ----------------------------------------------------------------
  // Serial configuration port
  // ----------------------------------------------------------------
  logic cs_active;
  logic [3:0] bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] next_frame;
  logic is_read;
  logic [6:0] frame_addr;
  logic [7:0] rd_word;
  logic sdo_bit;
  logic [7:0] reg_format;
  logic [7:0] reg_stab;
  logic [7:0] reg_form;

  assign cs_active = serial_mode & ~csn_lvl;
  assign next_frame = {shift_in[14:0], sdi_lvl};

  // Bit counter; releasing chip select abandons a partial frame.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 4'h0;
    end else if (!cs_active) begin
      bit_cnt <= 4'h0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Shift register, read flag and captured address.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_in <= 16'h0000;
      is_read <= 1'h0;
      frame_addr <= 7'h00;
      rd_word <= 8'h00;
    end else if (!cs_active) begin
      is_read <= 1'h0;
    end else if (sck_rise) begin
      shift_in <= next_frame;
      if (bit_cnt == 4'h0) begin
        is_read <= sdi_lvl;
      end
      if (bit_cnt == aoc_pkg::ADDR_LAST_CNT) begin
        frame_addr <= next_frame[6:0];
        rd_word <= reg_read(next_frame[6:0], reg_format, reg_stab, reg_form);
      end
    end
  end

  // Mode registers; they keep their values while chip select is high.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_format <= aoc_pkg::FORMAT_RST;
      reg_stab <= aoc_pkg::STAB_RST;
      reg_form <= aoc_pkg::FORM_RST;
    end else if (cs_active && sck_rise && bit_cnt == aoc_pkg::DATA_LAST_CNT && !is_read) begin
      case (frame_addr)
        aoc_pkg::ADDR_FORMAT: reg_format <= next_frame[7:0];
        aoc_pkg::ADDR_STAB: reg_stab <= next_frame[7:0];
        aoc_pkg::ADDR_FORM: reg_form <= next_frame[7:0];
        default: reg_format <= reg_format;
      endcase
    end
  end

  // Read-back bit changes after a falling edge, so the controller captures
  // it on the following falling edge with a full period of settling.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_bit <= 1'h1;
    end else if (!cs_active) begin
      sdo_bit <= 1'h1;
    end else if (sck_fall && is_read && bit_cnt[3]) begin
      sdo_bit <= rd_word[~bit_cnt[2:0]];
    end
  end

  // Open drain: the pin is only ever pulled low.
  assign sdo_out = 1'h0;
  assign sdo_oe = cs_active & is_read & ~sdo_bit;

  // ----------------------------------------------------------------
  // Effective controls: registers in serial mode, straps or fixed defaults in parallel
  // ----------------------------------------------------------------
  logic eff_stab;
  logic [1:0] eff_form;
  logic [1:0] eff_pwr;
  logic [1:0] eff_phase;
  logic eff_twos;
  logic [2:0] eff_cur;
  logic eff_term;

  always_comb begin
    if (serial_mode) begin
      eff_stab = reg_stab[aoc_pkg::STAB_EN_BIT];
      eff_form = reg_form[aoc_pkg::FORM_LSB +: 2];
      if (eff_form == 2'h3) begin
        eff_form = aoc_pkg::FORM_FULL;
      end
      eff_pwr = reg_format[aoc_pkg::FMT_PWR_LSB +: 2];
      eff_phase = reg_stab[aoc_pkg::STAB_PH_LSB +: 2];
      eff_twos = reg_format[aoc_pkg::FMT_TWOS_BIT];
      eff_cur = reg_form[aoc_pkg::FORM_CUR_LSB +: 3];
      eff_term = reg_form[aoc_pkg::FORM_TERM_BIT];
    end else begin
      eff_stab = csn_lvl;
      eff_form = sck_lvl ? aoc_pkg::FORM_DDR_LVDS : aoc_pkg::FORM_FULL;
      eff_pwr = {sdi_lvl, sdoin_lvl};
      eff_phase = aoc_pkg::PHASE_NONE;
      eff_twos = 1'h0;
      eff_cur = aoc_pkg::CUR_DEFAULT;
      eff_term = 1'h0;
    end
  end

  // Control outputs are registered to keep them glitch free.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stabilizer_enable <= 1'h0;
      power_state <= aoc_pkg::PWR_AWAKE;
      lvds_select <= 1'h0;
      lvds_drive_current <= aoc_pkg::CUR_DEFAULT;
      lvds_termination <= 1'h0;
    end else begin
      stabilizer_enable <= eff_stab;
      power_state <= eff_pwr;
      lvds_select <= (eff_form == aoc_pkg::FORM_DDR_LVDS);
      lvds_drive_current <= eff_cur;
      lvds_termination <= eff_term;
    end
  end

  // ----------------------------------------------------------------
  // Nap detection and conversion start
  // ----------------------------------------------------------------
  logic [7:0] idle_cnt;
  logic awake;

  // Without an encode edge for the nap time the core naps.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt <= 8'h00;
      nap_state <= 1'h0;
    end else if (enc_rise) begin
      idle_cnt <= 8'h00;
      nap_state <= 1'h0;
    end else if (idle_cnt == aoc_pkg::NAP_COUNT - 8'h01) begin
      nap_state <= 1'h1;
    end else begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  assign awake = (eff_pwr == aoc_pkg::PWR_AWAKE) & ~nap_state;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_start <= 1'h0;
    end else begin
      conv_start <= enc_rise & awake;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer and output stage
  // ----------------------------------------------------------------
  logic buf_valid;
  logic [16:0] buf_data;
  logic [15:0] fmt_code;
  logic [15:0] show_word;
  logic [15:0] hold_word;
  logic clk_raw;
  logic [2:0] clk_dly;
  logic [3:0] clk_taps;

  // The buffer absorbs a result that arrives while the previous one still
  // waits for its encode edge; a full buffer stalls the core.
  aoc_pair_buffer #(.W(aoc_pkg::SAMPLE_W + 1)) u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data({conv_over, conv_code}),
    .out_valid(buf_valid),
    .out_ready(enc_rise),
    .out_data(buf_data)
  );

  // The core codes offset binary; flipping the MSB gives two's complement.
  assign fmt_code = {buf_data[15] ^ eff_twos, buf_data[14:0]};
  assign show_word = buf_valid ? fmt_code : hold_word;

  // Encode rise: clock low, new word out. Encode fall: clock high, odd bits in double rate.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_raw <= 1'h0;
      hold_word <= 16'h0000;
      range_exceeded_flag <= 1'h0;
      sample_bits <= 16'h0000;
      paired_bit_lanes <= 8'h00;
    end else if (enc_rise) begin
      clk_raw <= 1'h0;
      hold_word <= show_word;
      if (buf_valid) begin
        range_exceeded_flag <= buf_data[16];
      end
      if (eff_form == aoc_pkg::FORM_FULL) begin
        sample_bits <= show_word;
        paired_bit_lanes <= 8'h00;
      end else begin
        sample_bits <= 16'h0000;
        paired_bit_lanes <= lane_bits(show_word, 1'h0);
      end
    end else if (enc_fall) begin
      clk_raw <= 1'h1;
      if (eff_form != aoc_pkg::FORM_FULL) begin
        paired_bit_lanes <= lane_bits(hold_word, 1'h1);
      end
    end
  end

  // Phase delay is in whole clk cycles, so its resolution is 10 ns.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_dly <= 3'h0;
    end else begin
      clk_dly <= {clk_dly[1:0], clk_raw};
    end
  end

  assign clk_taps = {clk_dly, clk_raw};
  assign output_clock_pos = clk_taps[eff_phase];
  assign output_clock_neg = ~clk_taps[eff_phase];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  clock_inverse_a: assert property (output_clock_neg == ~output_clock_pos)
    else $error("Negative output clock is not the inverse.");
  sdo_drive_a: assert property (sdo_oe |-> (cs_active && is_read && !sdo_out))
    else $error("Data out driven outside read-back or high.");
  regs_idle_a: assert property (!cs_active |=> $stable(reg_stab) && $stable(reg_form) && $stable(reg_format))
    else $error("Mode register changed with chip select high.");
  shift_sample_a: assert property (cs_active && sck_rise |=> shift_in[0] == $past(sdi_lvl))
    else $error("Serial data not sampled on clock rise.");
  sdo_timing_a: assert property ($changed(sdo_bit) |-> $past(sck_fall) || $past(!cs_active))
    else $error("Read-back bit changed away from a falling edge.");
  par_form_a: assert property (!serial_mode |-> eff_form != aoc_pkg::FORM_DDR_CMOS)
    else $error("Double-rate CMOS chosen in parallel mode.");
  par_stab_a: assert property (!serial_mode ##1 !serial_mode |-> stabilizer_enable == $past(csn_lvl))
    else $error("Stabilizer does not follow chip select strap.");
  start_edge_a: assert property (enc_rise && awake |=> conv_start ##1 !conv_start)
    else $error("Conversion start missing after encode rise.");
  nap_entry_a: assert property (idle_cnt == aoc_pkg::NAP_COUNT - 8'h01 && !enc_rise |=> nap_state)
    else $error("Nap not entered after idle time.");
  clock_fall_a: assert property (enc_rise |=> !clk_raw && hold_word == $past(show_word))
    else $error("Data and clock fall not together.");
  odd_lane_a: assert property (eff_form != aoc_pkg::FORM_FULL && enc_fall |=> clk_raw
                               && paired_bit_lanes == lane_bits(hold_word, 1'h1))
    else $error("Odd bits not on lanes while clock high.");
  full_word_a: assert property (eff_form == aoc_pkg::FORM_FULL && enc_rise && buf_valid |=>
                                sample_bits == hold_word && paired_bit_lanes == 8'h00)
    else $error("Full-rate word not on parallel outputs.");
  range_flag_a: assert property (enc_rise && buf_valid |=> range_exceeded_flag == $past(buf_data[16]))
    else $error("Range flag does not match its sample.");
  twos_msb_a: assert property (enc_rise && buf_valid && eff_twos |=> hold_word[15] != $past(buf_data[15]))
    else $error("Two's complement MSB not inverted.");

endmodule // aoc_adc_port

//--- aoc_core_model.sv
// Behavioural conversion core that feeds the output port through its handshake.
// Assumes the port's clk and nrst; each start or push is answered after LAT cycles.
module aoc_core_model #(
  parameter int LAT = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic conv_start,
  input wire logic push,
  input wire logic conv_ready,
  output logic conv_valid,
  output logic [15:0] conv_code,
  output logic conv_over
);
  logic [3:0] wait_cnt;
  logic [15:0] acc;
  logic par;
  // Word j is j times a fixed step and odd words are flagged out of range.
  // A taken word is replaced by its inverse so a stale value never passes for a fresh one.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 4'h0;
      conv_valid <= 1'b0;
      conv_code <= 16'h0000;
      conv_over <= 1'b0;
      acc <= 16'h0000;
      par <= 1'b0;
    end else begin
      if (conv_start || push) begin
        wait_cnt <= 4'(LAT);
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      if (wait_cnt == 4'h1) begin
        conv_valid <= 1'b1;
        conv_code <= acc + 16'h1357;
        conv_over <= ~par;
        acc <= acc + 16'h1357;
        par <= ~par;
      end else if (conv_valid && conv_ready) begin
        conv_valid <= 1'b0;
        conv_code <= ~conv_code;
        conv_over <= ~conv_over;
      end
    end
  end
endmodule // aoc_core_model

//--- adc_output_and_config_port_test.sv
// Self-checking bench for the converter output stream and configuration port.
// Assumes a free-running encode, single-ended and later differential, and a pulled-up open-drain read-back line.
module adc_output_and_config_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] form; logic [7:0] fmt; logic [7:0] stab; logic [5:0] exp;} aoc_row_type;
  logic clk = 1'b0, nrst = 1'b0, encode_pos = 1'b0, pss = 1'b0, cs_n = 1'b1, sck = 1'b0, sdi = 1'b0;
  logic sdo_drv = 1'b0, push = 1'b0, sdo_out, sdo_oe, conv_start, conv_valid, conv_ready, conv_over;
  logic range_exceeded_flag, output_clock_pos, output_clock_neg, lvds_select, lvds_termination;
  logic stabilizer_enable, nap_state, ddr = 1'b0, twos = 1'b0, chk_on = 1'b0, enc_run = 1'b0, enc_diff = 1'b0;
  logic [15:0] conv_code, sample_bits;
  logic [7:0] paired_bit_lanes, rd;
  logic [2:0] lvds_drive_current;
  logic [1:0] power_state;
  wire sdo_in;
  int fails = 0, samples_checked = 0, rises = 0;
  aoc_row_type rows [4] = '{'{8'h00, 8'h00, 8'h01, 6'h01}, '{8'h01, 8'h01, 8'h00, 6'h00},
                            '{8'h3E, 8'h00, 8'h07, 6'h3F}, '{8'h03, 8'h01, 8'h00, 6'h00}};
  // In serial mode the read-back line floats high through the board pull-up unless the port pulls it low; with the select pin high the bench drives it.
  assign sdo_in = pss ? sdo_drv : (sdo_oe ? sdo_out : 1'b1);
  always #5 clk = ~clk;
  // The complement input is grounded, or later driven as the inverse for differential encode.
  aoc_adc_port dut (.clk(clk), .nrst(nrst), .encode_pos(encode_pos), .encode_neg(enc_diff & ~encode_pos),
    .program_style_select(pss), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_in(sdo_in), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .conv_start(conv_start), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .conv_code(conv_code), .conv_over(conv_over), .sample_bits(sample_bits),
    .paired_bit_lanes(paired_bit_lanes), .range_exceeded_flag(range_exceeded_flag),
    .output_clock_pos(output_clock_pos), .output_clock_neg(output_clock_neg), .lvds_select(lvds_select),
    .lvds_drive_current(lvds_drive_current), .lvds_termination(lvds_termination),
    .stabilizer_enable(stabilizer_enable), .power_state(power_state), .nap_state(nap_state));
  aoc_core_model #(.LAT(3)) core (.clk(clk), .nrst(nrst), .conv_start(conv_start), .push(push),
    .conv_ready(conv_ready), .conv_valid(conv_valid), .conv_code(conv_code), .conv_over(conv_over));
  task automatic end_sim();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  // One serial frame, most significant bit first; read-back bits are taken at the falling edges.
  task automatic xfer(input logic csl, input logic [15:0] f);
    rd = 8'h00;
    cs_n = csl;
    for (int i = 0; i <= 16; i++) begin
      if (i >= 9) rd[16 - i] = sdo_in;
      sck = 1'b0;
      if (i == 16) break;
      sdi = f[15 - i];
      repeat (8) @(negedge clk);
      sck = 1'b1;
      repeat (8) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic wait_rises(input int n);
    int r0;
    r0 = rises;
    wait (rises >= r0 + n);
  endtask
  // Word shown after rise k is conversion k-1, so the expectation follows from the edge count.
  task automatic check_word(input logic hi);
    logic [15:0] w;
    w = 16'((rises - 1) * 16'h1357) ^ {twos, 15'h0000};
    cmp1(output_clock_pos, hi);
    cmp1(output_clock_neg, ~hi);
    cmp1(range_exceeded_flag, 1'(rises - 1));
    if (!ddr) cmp16(sample_bits, w);
    else for (int i = 0; i < 8; i++) cmp1(paired_bit_lanes[i], w[2 * i + int'(hi)]);
  endtask
  // Free-running encode; it pauses only when the main sequence stops it.
  initial begin
    wait (enc_run);
    forever begin
      encode_pos = 1'b1;
      rises++;
      repeat (10) @(negedge clk);
      if (chk_on) check_word(1'b0);
      encode_pos = 1'b0;
      repeat (10) @(negedge clk);
      if (chk_on) check_word(1'b1);
      if (!enc_run) wait (enc_run);
    end
  end
  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    end_sim();
  end
  // Main sequence: configuration rows with streaming, then the awkward cases.
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    enc_run = 1'b1;
    foreach (rows[r]) begin
      chk_on = 1'b0;
      xfer(1'b0, {1'b0, aoc_pkg::ADDR_FORM, rows[r].form});
      xfer(1'b0, {1'b0, aoc_pkg::ADDR_FORMAT, rows[r].fmt});
      xfer(1'b0, {1'b0, aoc_pkg::ADDR_STAB, rows[r].stab});
      xfer(1'b0, {1'b1, aoc_pkg::ADDR_FORM, 8'h00});
      cmp16({8'h00, rd}, {8'h00, rows[r].form});
      cmp16({10'h000, lvds_select, lvds_drive_current, lvds_termination, stabilizer_enable},
            {10'h000, rows[r].exp});
      ddr = (rows[r].form[1:0] == 2'h1) || (rows[r].form[1:0] == 2'h2);
      twos = rows[r].fmt[0];
      wait_rises(2);
      chk_on = 1'b1;
      wait_rises(3);
    end
    chk_on = 1'b0;
    xfer(1'b1, {1'b0, aoc_pkg::ADDR_FORM, 8'h02});
    xfer(1'b0, {1'b1, aoc_pkg::ADDR_FORM, 8'h00});
    cmp16({8'h00, rd}, 16'h0003);
    xfer(1'b0, {1'b1, 7'h7F, 8'h00});
    cmp16({8'h00, rd}, 16'h0000);
    cmp1(nap_state, 1'b0);
    enc_run = 1'b0;
    repeat (230) @(negedge clk);
    cmp1(nap_state, 1'b1);
    // The select strap only changes across a reset, as a board re-strapped while powered down.
    nrst = 1'b0;
    pss = 1'b1;
    sck = 1'b1;
    sdi = 1'b1;
    @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    cmp16({12'h000, stabilizer_enable, lvds_select, power_state}, 16'h000E);
    cmp1(sdo_oe, 1'b0);
    // The straps hold the core asleep, so only pushes fill the buffer; the third one waits.
    for (int i = 0; i < 3; i++) begin
      push = 1'b1;
      @(negedge clk);
      push = 1'b0;
      repeat (6) @(negedge clk);
    end
    cmp1(conv_ready, 1'b0);
    enc_diff = 1'b1;
    enc_run = 1'b1;
    wait_rises(4);
    cmp1(conv_ready, 1'b1);
    cs_n = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
    sdo_drv = 1'b1;
    repeat (8) @(negedge clk);
    cmp16({12'h000, stabilizer_enable, lvds_select, power_state}, 16'h0001);
    end_sim();
  end
endmodule // adc_output_and_config_port_test
